// ---- rtl/csfr_regs.sv ----
// Operation
// RL1: bit7 status one shows input overvoltage, bit6 shows input valid.
// RL2: bit5 status one shows input current limited by blocking transistor.
// RL3: bit4 status one shows die thermal regulation limiting charge current.
// RL4: bit3 charge done latches at cycle end, stays set past recharge.
// RL5: status one bits 2:0 carry the charger state code.
// RL6: status two bits 7:5 carry the thermistor zone code.
// RL7: recharge info bit driven only when recharge disabled and state complete.
// RL8: active recharge info reads one when battery below recharge threshold.
// RL9: status two bits 2:0 carry the battery voltage band.
// RL10: fault bit3 set when a shorted battery is detected.
// RL11: fault bit1 lower overtemperature, fault bit0 upper overtemperature.
// RL12: fault bits hold until host writes one or supply cycles.
// RL13: status one register sits at address 0x0b.
// RL14: unused bits read zero and ignore writes.
`timescale 1ns/10ps
module csfr_regs
  import csfr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input csfr_analog_t analog,
  input csfr_fault_ev_t fault_events,
  input wire logic supply_lost,
  input wire logic auto_recharge_disable,
  input wire logic charge_done_clear,
  input csfr_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic [7:0] fault_flags
);

  ////////////////////////////////////////////////////////////////////////
  // charge done latch and fault register

  logic done_r;
  logic done_nxt;
  logic fault_wr;

  // done only falls on charge_done_clear or supply_lost, not on a recharge crossing
  always_comb begin
    done_nxt = done_r;
    if (charge_done_clear || supply_lost) begin
      done_nxt = 1'b0;
    end
    if (analog.charge_cycle_end) begin
      done_nxt = 1'b1; // RL4
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done_r <= CSFR_DONE_RESET;
    end else begin
      done_r <= done_nxt;
    end
  end

  assign fault_wr = req.wr && (req.addr == CSFR_ADDR_FAULT);

  csfr_fault_latch u_fault (
    .clk(clk),
    .reset(reset),
    .supply_lost(supply_lost),
    .events(fault_events),
    .clear_strobe(fault_wr),
    .clear_bits(req.wdata),
    .fault_flags(fault_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // status images

  logic [7:0] status_one;
  logic [7:0] status_two;

  always_comb begin
    status_one = 8'h00;
    status_one[CSFR_S1_OV_BIT] = analog.input_overvoltage_flag; // RL1
    status_one[CSFR_S1_VALID_BIT] = analog.input_valid_flag; // RL1
    status_one[CSFR_S1_ILIM_BIT] = analog.input_current_limited_flag; // RL2
    status_one[CSFR_S1_THERM_BIT] = analog.die_thermal_limit_flag; // RL3
    status_one[CSFR_S1_DONE_BIT] = done_r; // RL4
    status_one[2:0] = analog.charger_state; // RL5
    status_two = 8'h00; // RL14
    status_two[7:5] = analog.thermistor_zone_code; // RL6
    if (auto_recharge_disable
        && analog.charger_state == CSFR_CHG_COMPLETE) begin // RL7
      status_two[CSFR_S2_RCH_BIT] = analog.below_recharge_threshold; // RL8
    end
    status_two[2:0] = analog.battery_band; // RL9
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: data registered one cycle after the read request

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  always_comb begin
    rvalid_nxt = req.rd;
    rdata_nxt = rdata_r;
    if (req.rd) begin
      if (req.addr == CSFR_ADDR_STATUS_ONE) begin // RL13
        rdata_nxt = status_one;
      end else if (req.addr == CSFR_ADDR_STATUS_TWO) begin
        rdata_nxt = status_two;
      end else if (req.addr == CSFR_ADDR_FAULT) begin
        rdata_nxt = fault_flags; // RL14
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= CSFR_RDATA_RESET;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;

endmodule : csfr_regs

// ---- rtl/csfr_pkg.sv ----
package csfr_pkg;

  localparam logic [7:0] CSFR_ADDR_STATUS_ONE = 8'h0b;
  localparam logic [7:0] CSFR_ADDR_STATUS_TWO = 8'h0c;
  localparam logic [7:0] CSFR_ADDR_FAULT = 8'h0d;

  // status one fields
  localparam int CSFR_S1_OV_BIT = 7;
  localparam int CSFR_S1_VALID_BIT = 6;
  localparam int CSFR_S1_ILIM_BIT = 5;
  localparam int CSFR_S1_THERM_BIT = 4;
  localparam int CSFR_S1_DONE_BIT = 3;
  // status two fields
  localparam int CSFR_S2_RCH_BIT = 3;
  // fault fields
  localparam int CSFR_F_SHORT_BIT = 3;
  localparam int CSFR_F_LOWER_BIT = 1;
  localparam int CSFR_F_UPPER_BIT = 0;
  localparam logic [7:0] CSFR_FAULT_MASK = 8'h0b;
  localparam logic [7:0] CSFR_FAULT_RESET = 8'h00;
  localparam logic CSFR_DONE_RESET = 1'b0;
  localparam logic [7:0] CSFR_RDATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    CSFR_CHG_OFF = 3'h0,
    CSFR_CHG_TRICKLE = 3'h1,
    CSFR_CHG_FAST_CC = 3'h2,
    CSFR_CHG_FAST_CV = 3'h3,
    CSFR_CHG_COMPLETE = 3'h4,
    CSFR_CHG_LDO = 3'h5,
    CSFR_CHG_TIMEOUT = 3'h6,
    CSFR_CHG_DETECT = 3'h7
  } csfr_chg_t;

  typedef enum logic [2:0] {
    CSFR_THR_OFF = 3'h0,
    CSFR_THR_COLD = 3'h1,
    CSFR_THR_COOL = 3'h2,
    CSFR_THR_WARM = 3'h3,
    CSFR_THR_HOT = 3'h4,
    CSFR_THR_OK = 3'h7
  } csfr_thr_t;

  typedef enum logic [2:0] {
    CSFR_BAT_MON_OFF = 3'h0,
    CSFR_BAT_NONE = 3'h1,
    CSFR_BAT_DEAD = 3'h2,
    CSFR_BAT_WEAK = 3'h3,
    CSFR_BAT_GOOD = 3'h4
  } csfr_bat_t;

  typedef struct packed {
    logic input_overvoltage_flag;
    logic input_valid_flag;
    logic input_current_limited_flag;
    logic die_thermal_limit_flag;
    logic charge_cycle_end;
    csfr_chg_t charger_state;
    csfr_thr_t thermistor_zone_code;
    logic below_recharge_threshold;
    csfr_bat_t battery_band;
  } csfr_analog_t;

  typedef struct packed {
    logic battery_short_fault;
    logic lower_overtemp_fault;
    logic upper_overtemp_fault;
  } csfr_fault_ev_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csfr_req_t;

endpackage : csfr_pkg

// ---- rtl/csfr_fault_latch.sv ----
`timescale 1ns/10ps
module csfr_fault_latch
  import csfr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic supply_lost,
  input csfr_fault_ev_t events,
  input wire logic clear_strobe,
  input wire logic [7:0] clear_bits,
  output logic [7:0] fault_flags
);

  logic [7:0] fault_r;
  logic [7:0] fault_nxt;
  logic [7:0] set_bits;

  always_comb begin
    set_bits = 8'h00;
    set_bits[CSFR_F_SHORT_BIT] = events.battery_short_fault; // RL10
    set_bits[CSFR_F_LOWER_BIT] = events.lower_overtemp_fault; // RL11
    set_bits[CSFR_F_UPPER_BIT] = events.upper_overtemp_fault; // RL11
    fault_nxt = fault_r;
    if (clear_strobe) begin
      fault_nxt = fault_nxt & ~clear_bits; // RL12
    end
    // a new event in the clear cycle wins over the clear; only supply_lost in that cycle drops it
    fault_nxt = (fault_nxt | set_bits) & CSFR_FAULT_MASK; // RL14
    if (supply_lost) begin
      fault_nxt = CSFR_FAULT_RESET; // RL12
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_r <= CSFR_FAULT_RESET;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  assign fault_flags = fault_r;

endmodule : csfr_fault_latch

// ---- bench/csfr_regs_asserts.sv ----
`timescale 1ns/10ps
module csfr_regs_asserts
  import csfr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input csfr_analog_t analog,
  input csfr_fault_ev_t fault_events,
  input wire logic supply_lost,
  input wire logic auto_recharge_disable,
  input csfr_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [7:0] fault_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rd_answer: assert property (req.rd |=> rvalid)
    else $error("read request not answered");
  a_rv_cause: assert property (rvalid |-> $past(req.rd))
    else $error("read valid without a request");
  a_s1_read: assert property (
    req.rd && req.addr == CSFR_ADDR_STATUS_ONE |=>
    rdata[7:4] == $past({analog.input_overvoltage_flag,
    analog.input_valid_flag, analog.input_current_limited_flag,
    analog.die_thermal_limit_flag})
    && rdata[2:0] == $past(analog.charger_state))
    else $error("status one read wrong");
  a_s2_read: assert property (
    req.rd && req.addr == CSFR_ADDR_STATUS_TWO |=>
    rdata[7:4] == {$past(analog.thermistor_zone_code), 1'b0}
    && rdata[2:0] == $past(analog.battery_band))
    else $error("status two read wrong");
  a_rch_info: assert property (
    req.rd && req.addr == CSFR_ADDR_STATUS_TWO |=>
    rdata[CSFR_S2_RCH_BIT] == $past(analog.below_recharge_threshold
    && analog.charger_state == CSFR_CHG_COMPLETE
    && auto_recharge_disable))
    else $error("recharge info bit wrong");
  a_short_set: assert property (
    fault_events.battery_short_fault && !supply_lost
    |=> fault_flags[CSFR_F_SHORT_BIT])
    else $error("battery short fault not latched");
  a_temp_set: assert property (
    !supply_lost |=> (fault_flags[1:0]
    & $past({fault_events.lower_overtemp_fault,
    fault_events.upper_overtemp_fault}))
    == $past({fault_events.lower_overtemp_fault,
    fault_events.upper_overtemp_fault}))
    else $error("overtemperature fault not latched");
  a_fault_hold: assert property (
    !supply_lost && !req.wr
    |=> (fault_flags & $past(fault_flags)) == $past(fault_flags))
    else $error("fault flag dropped without clear");
  a_supply_clr: assert property (supply_lost |=> fault_flags == 8'h00)
    else $error("supply loss did not clear faults");
  a_unused_zero: assert property (
    (fault_flags & ~CSFR_FAULT_MASK) == 8'h00)
    else $error("unused fault bit set");
  c_clear: cover property (req.wr && req.addr == CSFR_ADDR_FAULT);
  c_rch: cover property (rvalid && rdata[3]);
  c_sl: cover property (supply_lost && fault_flags != 8'h00);
endmodule : csfr_regs_asserts

// ---- bench/csfr_host.sv ----
`timescale 1ns/10ps
module csfr_host
  import csfr_pkg::*;
(
  input wire logic clk,
  output csfr_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  // released lines show inverted address and data, never a stale match
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) req = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk) req = '{1'b0, 1'b0, ~a, 8'hff};
    d = rvalid ? rdata : 8'hxx;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) req = '{1'b0, 1'b1, a, d};
    @(negedge clk) req = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
endmodule : csfr_host

// ---- bench/tb_charger_status_fault_regs.sv ----
`timescale 1ns/10ps
module tb_charger_status_fault_regs
  import csfr_pkg::*;
;
  logic clk = 0, reset = 1, sl = 0, ard = 0, cdc = 0, rvalid;
  logic [7:0] rdata, ff;
  csfr_analog_t an = '0;
  csfr_fault_ev_t fev = '0;
  csfr_req_t req;
  int err_count = 0, checks = 0;
  always #5 clk = ~clk;
  csfr_regs u_dut(.clk, .reset, .analog(an), .fault_events(fev),
    .supply_lost(sl), .auto_recharge_disable(ard),
    .charge_done_clear(cdc), .req, .rdata, .rvalid, .fault_flags(ff));
  csfr_host u_host(.clk, .req, .rdata, .rvalid);
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    checks++;
    if (d !== e) begin
      err_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, d);
    end
  endtask : rc
  task automatic final_report();
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic t_status();
    an = '{1, 0, 1, 0, 0, CSFR_CHG_FAST_CV, CSFR_THR_COOL, 1, CSFR_BAT_WEAK};
    rc(8'h0b, 8'ha3);
    rc(8'h0c, 8'h43);
    for (int i = 0; i < 8; i++) begin
      an.charger_state = csfr_chg_t'(i);
      rc(8'h0b, {5'h14, i[2:0]});
    end
    an = '{0, 1, 0, 1, 0, CSFR_CHG_COMPLETE, CSFR_THR_OK, 1, CSFR_BAT_NONE};
    ard = 1;
    rc(8'h0c, 8'he9);
    an.below_recharge_threshold = 0;
    rc(8'h0c, 8'he1);
    rc(8'h20, 8'h00);
  endtask : t_status
  task automatic t_done();
    an.charge_cycle_end = 1;
    @(negedge clk) an.charge_cycle_end = 0;
    an.below_recharge_threshold = 1;
    rc(8'h0b, 8'h5c);
    cdc = 1;
    @(negedge clk) cdc = 0;
    rc(8'h0b, 8'h54);
  endtask : t_done
  task automatic t_fault();
    fev = 3'h7;
    @(negedge clk) fev = 3'h0;
    rc(8'h0d, 8'h0b);
    checks++;
    if (ff !== 8'h0b) begin
      err_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, 8'h0b, ff);
    end
    u_host.wr(8'h0d, 8'hf4);
    u_host.wr(8'h0b, 8'hff);
    rc(8'h0d, 8'h0b);
    u_host.wr(8'h0d, 8'h09);
    rc(8'h0d, 8'h02);
    sl = 1;
    @(negedge clk) sl = 0;
    rc(8'h0d, 8'h00);
  endtask : t_fault
  initial begin
    repeat (3) @(negedge clk);
    reset = 0;
    t_status();
    t_done();
    t_fault();
    final_report();
  end
  initial begin
    #20000;
    err_count++;
    final_report();
  end
endmodule : tb_charger_status_fault_regs
bind csfr_regs csfr_regs_asserts u_chk(.clk, .reset, .analog,
  .fault_events, .supply_lost, .auto_recharge_disable, .req, .rdata,
  .rvalid, .fault_flags);
